// ### rtl/ddsl_defs.svh
// Purpose: Constants for the dual DAC serial load control block
// Assumes: Included by the package and by the top module, not by the synchroniser
// Notes: Word layout is command, channel mask, code, padding
`ifndef DDSL_DEFS_SVH
`define DDSL_DEFS_SVH

`define DDSL_WORD_BITS 24
`define DDSL_CODE_BITS 10
`define DDSL_CHANNELS 2
`define DDSL_LAST_BIT 5'h17
`define DDSL_ZERO_CODE 10'h000
`define DDSL_MID_CODE 10'h200
`define DDSL_CMD_HI 23
`define DDSL_CMD_LO 20
`define DDSL_MASK_HI 17
`define DDSL_MASK_LO 16
`define DDSL_CODE_HI 15
`define DDSL_CODE_LO 6
`define DDSL_PAD_BITS 6
`define DDSL_CMD_WRITE_IN 4'h1
`define DDSL_CMD_UPDATE 4'h2
`define DDSL_CMD_WRITE_UPD 4'h3
`define DDSL_CMD_READBACK 4'h9
`define DDSL_INIT_CYCLES 2'h3

`endif

// ### rtl/ddsl_pkg.sv
// Purpose: Types shared by the dual DAC serial load control block
// Assumes: ddsl_defs.svh holds the numeric constants
// Notes: Types only
`include "ddsl_defs.svh"

package ddsl_pkg;
    typedef logic [`DDSL_CODE_BITS-1:0] ddsl_code_type;
    typedef logic [`DDSL_WORD_BITS-1:0] ddsl_word_type;
    typedef enum logic [1:0] {
        DDSL_IDLE,
        DDSL_SHIFT,
        DDSL_DONE
    } ddsl_frame_type;
endpackage

// ### rtl/ddsl_sync.sv
// Purpose: Two-flop synchroniser for pins from outside the clock domain
// Assumes: Synchronous active-low reset
// Notes: First flop feeds only the second
`timescale 1ns/1ns

module ddsl_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] sync_nxt;

    if (WIDTH < 1) begin : g_check
        $error("ddsl_sync: WIDTH must be at least 1");
    end

    always_comb begin
        meta_nxt = i_async;
        sync_nxt = meta_r;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            meta_r <= RST_VAL;
            o_sync <= RST_VAL;
        end else begin
            meta_r <= meta_nxt;
            o_sync <= sync_nxt;
        end
    end
endmodule // ddsl_sync

// ### rtl/ddsl_top.sv
// Purpose: Serial load control for a dual 10-bit DAC
// Assumes: Serial clock far slower than i_clk; all pins asynchronous
// Notes: Link edges are found by sampling; no second clock domain
`timescale 1ns/1ns
`include "ddsl_defs.svh"

module ddsl_top (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_frame_sync_n,
    input wire logic i_serial_clk,
    input wire logic i_serial_data_in,
    input wire logic i_load_strobe_n,
    input wire logic i_dac_reset_n,
    input wire logic i_reset_level_select,
    output logic o_serial_data_out,
    output ddsl_pkg::ddsl_code_type o_dac_a_code,
    output ddsl_pkg::ddsl_code_type o_dac_b_code
);
    import ddsl_pkg::*;

    localparam int NCH = `DDSL_CHANNELS;

    logic sync_s;
    logic sclk_s;
    logic din_s;
    logic strobe_s;
    logic rstn_s;
    logic sel_s;

    // Idle levels as reset values avoid false edges after reset
    ddsl_sync #(.WIDTH(3), .RST_VAL(3'b111)) u_sync_hi (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_async({i_frame_sync_n, i_load_strobe_n, i_dac_reset_n}),
        .o_sync({sync_s, strobe_s, rstn_s})
    );

    ddsl_sync #(.WIDTH(3), .RST_VAL(3'b000)) u_sync_lo (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_async({i_serial_clk, i_serial_data_in, i_reset_level_select}),
        .o_sync({sclk_s, din_s, sel_s})
    );

    ddsl_frame_type state_r;
    ddsl_frame_type state_nxt;
    logic [4:0] cnt_r;
    logic [4:0] cnt_nxt;
    ddsl_word_type shreg_r;
    ddsl_word_type shreg_nxt;
    logic sdo_r;
    logic sdo_nxt;
    ddsl_code_type in_r [NCH];
    ddsl_code_type in_nxt [NCH];
    ddsl_code_type dac_r [NCH];
    ddsl_code_type dac_nxt [NCH];
    logic [NCH-1:0] pend_r;
    logic [NCH-1:0] pend_nxt;
    logic [1:0] init_r;
    logic [1:0] init_nxt;
    logic sclk_p_r;
    logic strobe_p_r;
    logic rstn_p_r;

    logic sclk_fall;
    logic sclk_rise;
    logic strobe_fall;
    logic pin_rst_fall;
    logic word_done;
    ddsl_word_type word;
    logic [3:0] cmd;
    logic [NCH-1:0] mask;
    ddsl_code_type code;

    function automatic ddsl_code_type reset_code(input logic sel);
        return sel ? `DDSL_MID_CODE : `DDSL_ZERO_CODE;
    endfunction

    assign sclk_fall = sclk_p_r & ~sclk_s;
    assign sclk_rise = ~sclk_p_r & sclk_s;
    assign strobe_fall = strobe_p_r & ~strobe_s;
    assign pin_rst_fall = rstn_p_r & ~rstn_s;
    assign word = {shreg_r[`DDSL_WORD_BITS-2:0], din_s};
    assign cmd = word[`DDSL_CMD_HI:`DDSL_CMD_LO];
    assign mask = word[`DDSL_MASK_HI:`DDSL_MASK_LO];
    assign code = word[`DDSL_CODE_HI:`DDSL_CODE_LO];

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        shreg_nxt = shreg_r;
        sdo_nxt = sdo_r;
        in_nxt = in_r;
        dac_nxt = dac_r;
        pend_nxt = pend_r;
        init_nxt = init_r;
        word_done = 1'b0;

        unique case (state_r)
            DDSL_IDLE: begin
                if (!sync_s) begin
                    state_nxt = DDSL_SHIFT;
                    cnt_nxt = 5'h00;
                    // Present first bit before the first falling edge
                    sdo_nxt = shreg_r[`DDSL_WORD_BITS-1];
                end
            end
            DDSL_SHIFT: begin
                // Early frame end drops the partial word
                if (sync_s) begin
                    state_nxt = DDSL_IDLE;
                end else if (sclk_fall) begin
                    shreg_nxt = word;
                    cnt_nxt = cnt_r + 5'h01;
                    if (cnt_r == `DDSL_LAST_BIT) begin
                        state_nxt = DDSL_DONE;
                        word_done = 1'b1;
                    end
                end
            end
            DDSL_DONE: begin
                // Extra bits only pass through for the next chained part
                if (sync_s) begin
                    state_nxt = DDSL_IDLE;
                end else if (sclk_fall) begin
                    shreg_nxt = word;
                end
            end
        endcase

        if (sclk_rise && !sync_s) begin
            sdo_nxt = shreg_r[`DDSL_WORD_BITS-1];
        end

        // Pin reset low blocks the strobe edge load only; a write with the strobe held low still loads
        if (strobe_fall && rstn_s) begin
            for (int i = 0; i < NCH; i++) begin
                if (pend_r[i]) begin
                    dac_nxt[i] = in_r[i];
                end
            end
            pend_nxt = '0;
        end

        if (word_done) begin
            unique case (cmd)
                `DDSL_CMD_WRITE_IN: begin
                    for (int i = 0; i < NCH; i++) begin
                        if (mask[i]) begin
                            in_nxt[i] = code;
                            if (!strobe_s) begin
                                dac_nxt[i] = code;
                                pend_nxt[i] = 1'b0;
                            end else begin
                                pend_nxt[i] = 1'b1;
                            end
                        end
                    end
                end
                `DDSL_CMD_UPDATE: begin
                    for (int i = 0; i < NCH; i++) begin
                        if (mask[i]) begin
                            dac_nxt[i] = in_r[i];
                            pend_nxt[i] = 1'b0;
                        end
                    end
                end
                `DDSL_CMD_WRITE_UPD: begin
                    for (int i = 0; i < NCH; i++) begin
                        if (mask[i]) begin
                            in_nxt[i] = code;
                            dac_nxt[i] = code;
                            pend_nxt[i] = 1'b0;
                        end
                    end
                end
                `DDSL_CMD_READBACK: begin
                    // Next frame shifts out the chosen input register
                    shreg_nxt = {cmd, 2'b00, mask,
                        mask[0] ? in_r[0] : in_r[1],
                        {`DDSL_PAD_BITS{1'b0}}};
                end
                default: begin
                end
            endcase
        end

        // Power-up load waits for the select pin to pass its synchroniser
        if (init_r != 2'h0) begin
            init_nxt = init_r - 2'h1;
            if (init_r == 2'h1) begin
                for (int i = 0; i < NCH; i++) begin
                    in_nxt[i] = reset_code(sel_s);
                    dac_nxt[i] = reset_code(sel_s);
                end
                pend_nxt = '0;
            end
        end

        if (pin_rst_fall) begin
            for (int i = 0; i < NCH; i++) begin
                in_nxt[i] = reset_code(sel_s);
                dac_nxt[i] = reset_code(sel_s);
            end
            pend_nxt = '0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            state_r <= DDSL_IDLE;
            cnt_r <= 5'h00;
            shreg_r <= '0;
            sdo_r <= 1'b0;
            for (int i = 0; i < NCH; i++) begin
                in_r[i] <= `DDSL_ZERO_CODE;
                dac_r[i] <= `DDSL_ZERO_CODE;
            end
            pend_r <= '0;
            init_r <= `DDSL_INIT_CYCLES;
            sclk_p_r <= 1'b0;
            strobe_p_r <= 1'b1;
            rstn_p_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            shreg_r <= shreg_nxt;
            sdo_r <= sdo_nxt;
            in_r <= in_nxt;
            dac_r <= dac_nxt;
            pend_r <= pend_nxt;
            init_r <= init_nxt;
            sclk_p_r <= sclk_s;
            strobe_p_r <= strobe_s;
            rstn_p_r <= rstn_s;
        end
    end

    assign o_serial_data_out = sdo_r;
    assign o_dac_a_code = dac_r[0];
    assign o_dac_b_code = dac_r[1];
endmodule // ddsl_top

// ### tb/ddsl_host.sv
// Purpose: Host model driving the serial write link
// Assumes: Serial clock stands high outside frames
// Notes: Data line flips when released, so stale bits never pass
`timescale 1ns/1ns
module ddsl_host (
    input wire logic i_clk,
    input wire logic i_sdo,
    output logic o_sync_n,
    output logic o_sclk,
    output logic o_sdi
);
    initial begin
        o_sync_n = 1'b1;
        o_sclk = 1'b1;
        o_sdi = 1'b0;
    end
    task automatic half();
        repeat (4) @(posedge i_clk);
    endtask
    task automatic send(input logic [23:0] w, input int n,
            output logic [23:0] rx);
        rx = '0;
        o_sync_n <= 1'b0;
        half();
        for (int i = 0; i < n; i++) begin
            o_sdi <= w[23-i];
            half();
            o_sclk <= 1'b0;
            rx = {rx[22:0], i_sdo};
            half();
            // No rise after the last bit: keeps loaded data in place
            if (i < n - 1) o_sclk <= 1'b1;
        end
        half();
        o_sync_n <= 1'b1;
        o_sdi <= ~o_sdi;
        half();
        o_sclk <= 1'b1;
        half();
    endtask
endmodule // ddsl_host

// ### tb/ddsl_top_checker.sv
// Purpose: Port assertions for the serial load control block
// Assumes: Reset level select held steady around resets
// Notes: Bound into ddsl_top
`timescale 1ns/1ns
module ddsl_top_checker (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_frame_sync_n,
    input wire logic i_serial_clk,
    input wire logic i_serial_data_in,
    input wire logic i_load_strobe_n,
    input wire logic i_dac_reset_n,
    input wire logic i_reset_level_select,
    input wire logic o_serial_data_out,
    input wire ddsl_pkg::ddsl_code_type o_dac_a_code,
    input wire ddsl_pkg::ddsl_code_type o_dac_b_code
);
    import ddsl_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    ddsl_code_type rc;
    assign rc = i_reset_level_select ? 10'h200 : 10'h000;
    a_rst_zero: assert property ($rose(i_rst_b) |->
        o_dac_a_code == 10'h000 && o_dac_b_code == 10'h000)
        else $error("codes not zero in reset");
    a_sdo_zero: assert property ($rose(i_rst_b) |->
        o_serial_data_out == 1'b0) else $error("data out not zero");
    a_power_level: assert property ($rose(i_rst_b) |-> ##[1:4]
        (o_dac_a_code == rc && o_dac_b_code == rc))
        else $error("power-up code wrong");
    a_pin_reset: assert property ($fell(i_dac_reset_n) |-> ##[1:6]
        (o_dac_a_code == rc && o_dac_b_code == rc))
        else $error("pin reset code wrong");
    a_pin_hold: assert property (!i_dac_reset_n && i_load_strobe_n &&
        $past(i_dac_reset_n, 6) == 1'b0 |-> o_dac_a_code == rc &&
        o_dac_b_code == rc) else $error("code left reset level");
    a_strobe_ignore: assert property ($fell(i_load_strobe_n) &&
        !i_dac_reset_n && $past(i_dac_reset_n, 8) == 1'b0 &&
        i_frame_sync_n |=> ($stable(o_dac_a_code) &&
        $stable(o_dac_b_code))[*5]) else $error("strobe not ignored");
    a_codes_idle: assert property (($stable(i_load_strobe_n) &&
        $stable(i_dac_reset_n) && i_frame_sync_n)[*8] |=>
        $stable(o_dac_a_code) && $stable(o_dac_b_code))
        else $error("code moved with no cause");
    a_sdo_rise: assert property ($changed(o_serial_data_out) &&
        i_serial_clk && !i_frame_sync_n |-> $past(i_serial_clk, 2))
        else $error("data out moved off rising edge");
endmodule // ddsl_top_checker

bind ddsl_top ddsl_top_checker u_ddsl_top_checker (.i_clk(i_clk),
    .i_rst_b(i_rst_b), .i_frame_sync_n(i_frame_sync_n),
    .i_serial_clk(i_serial_clk), .i_serial_data_in(i_serial_data_in),
    .i_load_strobe_n(i_load_strobe_n), .i_dac_reset_n(i_dac_reset_n),
    .i_reset_level_select(i_reset_level_select),
    .o_serial_data_out(o_serial_data_out), .o_dac_a_code(o_dac_a_code),
    .o_dac_b_code(o_dac_b_code));

// ### tb/ddsl_top_bench.sv
// Purpose: Self-checking bench for the serial load control block
// Assumes: Host model drives the link; pins change at rising edges
// Notes: DAC codes are judged at falling edges, clear of updates
`timescale 1ns/1ns
module ddsl_top_bench;
    import ddsl_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic load_strobe_n = 1'b1;
    logic dac_reset_n = 1'b1;
    logic level_sel = 1'b0;
    logic frame_sync_n, serial_clk, sdi, serial_data_out;
    ddsl_code_type code_a, code_b;
    logic [23:0] rx;
    int n_mismatch = 0;
    int checks = 0;
    always #25 i_clk = ~i_clk;
    ddsl_top u_ddsl_top (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_frame_sync_n(frame_sync_n), .i_serial_clk(serial_clk),
        .i_serial_data_in(sdi), .i_load_strobe_n(load_strobe_n),
        .i_dac_reset_n(dac_reset_n), .i_reset_level_select(level_sel),
        .o_serial_data_out(serial_data_out), .o_dac_a_code(code_a),
        .o_dac_b_code(code_b));
    ddsl_host u_ddsl_host (.i_clk(i_clk), .i_sdo(serial_data_out),
        .o_sync_n(frame_sync_n), .o_sclk(serial_clk), .o_sdi(sdi));
    task automatic check(input string what, input logic [23:0] seen,
            input logic [23:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    function automatic logic [23:0] wd(input logic [3:0] c,
            input logic [1:0] m, input logic [9:0] v);
        return {c, 2'b00, m, v, 6'h00};
    endfunction
    task automatic tx(input logic [23:0] w);
        u_ddsl_host.send(w, 24, rx);
        cyc(4);
    endtask
    task automatic codes(input logic [9:0] a, input logic [9:0] b);
        @(negedge i_clk);
        check("code a", {14'h0, code_a}, {14'h0, a});
        check("code b", {14'h0, code_b}, {14'h0, b});
        @(posedge i_clk);
    endtask
    task automatic pulse();
        load_strobe_n <= 1'b0;
        cyc(2);
        load_strobe_n <= 1'b1;
    endtask
    task automatic t_power(input logic sel);
        i_rst_b <= 1'b0;
        level_sel <= sel;
        cyc(20);
        i_rst_b <= 1'b1;
        cyc(6);
        codes(sel ? 10'h200 : 10'h000, sel ? 10'h200 : 10'h000);
    endtask
    task automatic t_write();
        tx(wd(4'h3, 2'b01, 10'h155));
        codes(10'h155, 10'h200);
        tx(wd(4'h3, 2'b10, 10'h2AA));
        codes(10'h155, 10'h2AA);
        u_ddsl_host.send(wd(4'h3, 2'b11, 10'h000), 12, rx);
        cyc(4);
        codes(10'h155, 10'h2AA);
    endtask
    task automatic t_strobe();
        tx(wd(4'h1, 2'b11, 10'h0F0));
        codes(10'h155, 10'h2AA);
        pulse();
        for (int i = 0; i < 10; i++) begin
            @(negedge i_clk);
            if (code_a === 10'h0F0) break;
        end
        check("strobe a", {14'h0, code_a}, {14'h0, 10'h0F0});
        check("strobe b", {14'h0, code_b}, {14'h0, 10'h0F0});
        if (code_a !== 10'h0F0) print_verdict();
        @(posedge i_clk);
        tx(wd(4'h1, 2'b01, 10'h321));
        tx(wd(4'h2, 2'b01, 10'h000));
        codes(10'h321, 10'h0F0);
    endtask
    task automatic t_held();
        load_strobe_n <= 1'b0;
        tx(wd(4'h1, 2'b10, 10'h3FF));
        codes(10'h321, 10'h3FF);
        load_strobe_n <= 1'b1;
    endtask
    task automatic t_pin();
        level_sel <= 1'b0;
        cyc(4);
        dac_reset_n <= 1'b0;
        cyc(8);
        codes(10'h000, 10'h000);
        tx(wd(4'h9, 2'b01, 10'h000));
        u_ddsl_host.send(24'h000000, 24, rx);
        check("readback", rx, wd(4'h9, 2'b01, 10'h000));
        tx(wd(4'h1, 2'b11, 10'h111));
        tx(wd(4'h9, 2'b10, 10'h000));
        u_ddsl_host.send(24'h000000, 24, rx);
        check("readback b", rx, wd(4'h9, 2'b10, 10'h111));
        pulse();
        cyc(8);
        codes(10'h000, 10'h000);
        dac_reset_n <= 1'b1;
        cyc(4);
        u_ddsl_host.send(24'hA5C3F0, 24, rx);
        u_ddsl_host.send(24'h000000, 24, rx);
        check("chain", rx, 24'hA5C3F0);
        // Midscale through the pin reset as well
        level_sel <= 1'b1;
        cyc(4);
        dac_reset_n <= 1'b0;
        cyc(8);
        codes(10'h200, 10'h200);
        dac_reset_n <= 1'b1;
        cyc(4);
    endtask
    initial begin
        t_power(1'b0);
        t_power(1'b1);
        t_write();
        t_strobe();
        t_held();
        t_pin();
        print_verdict();
    end
endmodule // ddsl_top_bench
